// *** design/orient_filter_pkg.sv ***
package orient_filter_pkg;
   // timing
   localparam longint CLK_HZ = 20_000_000;
   localparam longint CAL_TIME_S = 30;
   localparam longint CAL_CYCLES = CAL_TIME_S * CLK_HZ;
   localparam longint AXIS_TIME_S = 10;
   localparam longint AXIS_CYCLES = AXIS_TIME_S * CLK_HZ;
   localparam longint STILL_TIME_MS = 500;
   localparam longint STILL_CYCLES = STILL_TIME_MS * CLK_HZ / 1000;
   localparam longint OUT_RATE_HZ = 300;
   localparam longint OUT_GAP_CYCLES = (CLK_HZ + OUT_RATE_HZ - 1) / OUT_RATE_HZ;
   localparam longint ACQ_RATE_HZ = 500;
   localparam longint ACQ_GAP_CYCLES = CLK_HZ / ACQ_RATE_HZ;
   // arithmetic
   localparam int AVG_SHIFT = 6;
   localparam int BIAS_FRAC = 8;
   localparam int COEF_FRAC = 16;
   localparam logic [16:0] COEF_A100 = 17'h0199A;
   localparam logic [16:0] COEF_A050 = 17'h00CCD;
   localparam logic [16:0] COEF_A010 = 17'h0028F;
   localparam logic [16:0] COEF_A005 = 17'h00148;
   localparam logic [16:0] COEF_A001 = 17'h00042;
   // register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_THRESH = 8'h0C;
   localparam logic [7:0] REG_BIAS = 8'h10;
   localparam logic [7:0] REG_MATRIX = 8'h20;
   // control fields
   localparam int CTRL_LP_LSB = 0;
   localparam int CTRL_THR_BIT = 3;
   localparam int CTRL_AUTO_BIT = 4;
   localparam int CTRL_ROT_BIT = 5;
   localparam int CTRL_LIN_LSB = 6;
   // command fields
   localparam int CMD_BASIC_BIT = 0;
   localparam int CMD_ADV_BIT = 1;
   localparam int CMD_NEXT_BIT = 2;
   localparam int CMD_CLR_BIT = 3;
   // status fields
   localparam int STAT_BASIC_BIT = 0;
   localparam int STAT_ADV_BIT = 1;
   localparam int STAT_WAIT_BIT = 2;
   localparam int STAT_SLOW_BIT = 3;
   localparam int STAT_MOVE_BIT = 4;
   localparam int STAT_AXIS_LSB = 5;
   typedef enum logic [2:0] {
      LP_OFF = 3'h0, LP_A100 = 3'h1, LP_A050 = 3'h2,
      LP_A010 = 3'h3, LP_A005 = 3'h4, LP_A001 = 3'h5
   } lp_sel_type;
   typedef enum logic [1:0] {LIN_OFF = 2'h0, LIN_WEAK = 2'h1, LIN_STRONG = 2'h2} lin_mode_type;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1, ST_BASIC = 4'h2, ST_ADV = 4'h4, ST_WAIT = 4'h8
   } st_type;
   // reset values
   localparam lp_sel_type LP_RESET = LP_OFF;
   localparam logic THR_EN_RESET = 1'h0;
   localparam logic AUTO_EN_RESET = 1'h1;
   localparam logic ROT_EN_RESET = 1'h0;
   localparam lin_mode_type LIN_RESET = LIN_STRONG;
endpackage : orient_filter_pkg

// *** design/orient_filter.sv ***
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("fifo depth must be a power of two of at least 2");
   end
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } fifo_state_type;
   fifo_state_type r;
   fifo_state_type n;
   logic push;
   logic pop;
   assign in_ready = (r.count != (AW+1)'(DEPTH));
   assign out_valid = (r.count != '0);
   assign out_data = r.mem[r.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_comb begin
      n = r;
      if (push) begin
         n.mem[r.wr] = in_data;
         n.wr = r.wr + 1'b1;
      end
      if (pop) begin
         n.rd = r.rd + 1'b1;
      end
      n.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule : sample_fifo

// How it works
// - with smoothing on, each output is (1-a) times the previous output plus a times the new fused input; the first after a change of a passes through.
// - a is chosen among off, 0.1, 0.05, 0.01, 0.005 and 0.001, and off (the reset value) passes data through.
// - with thresholding on, the orientation only updates while the gyro moves; it is off after reset.
// - the gyro threshold is only ever set by the gyro calibration, never written directly.
// - with auto-calibration on (the default), after enough still time the gyro offset tracks live samples.
// - a basic calibration command runs about 30 s estimating bias and threshold, then returns to normal.
// - rotational acceleration compensation is a switch passed to fusion, off by default.
// - linear acceleration compensation has presets off, weak and strong, strong by default.
// - gyro samples must arrive at 500 Hz or faster and output samples leave no faster than 300 Hz.
// - an advanced calibration measures each axis upward in turn and rebuilds the gain and misalignment matrix.
module orient_filter
   import orient_filter_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter int GYRO_W = 16,
   parameter int FIFO_DEPTH = 32,
   parameter int unsigned CAL_CYC = 32'(CAL_CYCLES),
   parameter int unsigned AXIS_CYC = 32'(AXIS_CYCLES),
   parameter int unsigned STILL_CYC = 32'(STILL_CYCLES),
   parameter int unsigned OUT_GAP = 32'(OUT_GAP_CYCLES),
   parameter int unsigned ACQ_GAP = 32'(ACQ_GAP_CYCLES)
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // gyro samples
   input wire logic gyro_valid,
   input wire logic [GYRO_W-1:0] gyro_x,
   input wire logic [GYRO_W-1:0] gyro_y,
   input wire logic [GYRO_W-1:0] gyro_z,
   // fused orientation in
   input wire logic fused_valid,
   output logic fused_ready,
   input wire logic [DATA_W-1:0] fused_data,
   // filtered orientation out
   output logic out_valid,
   input wire logic out_ready,
   output logic [DATA_W-1:0] out_data,
   // fusion settings
   output logic [1:0] lin_acc_mode,
   output logic rot_acc_en
);
   localparam int BW = GYRO_W + BIAS_FRAC;
   localparam int AW = DATA_W + COEF_FRAC;
   if (DATA_W < 2 || DATA_W > 32 || GYRO_W < 2 || GYRO_W > 31 || CAL_CYC < 2 || AXIS_CYC < 2
       || STILL_CYC < 1 || OUT_GAP < 1 || ACQ_GAP < 2) begin : g_bad
      $error("orient_filter parameters out of range");
   end
   typedef struct packed {
      st_type st;
      lp_sel_type lp;
      logic thr_en;
      logic auto_en;
      logic rot_en;
      lin_mode_type lin;
      logic prime;
      logic [31:0] cal_cnt;
      logic [31:0] still_cnt;
      logic [31:0] acq_cnt;
      logic [31:0] gap_cnt;
      logic slow;
      logic moving;
      logic [1:0] axis;
      logic [2:0][BW-1:0] bias;
      logic [8:0][BW-1:0] mat;
      logic [GYRO_W:0] thr;
      logic [AW-1:0] acc;
      logic [DATA_W-1:0] last;
      logic st_valid;
      logic [DATA_W-1:0] st_data;
      logic fused_ready;
      logic out_valid;
      logic [DATA_W-1:0] out_data;
      logic [31:0] rdata;
   } state_type;
   state_type r;
   state_type n;
   logic [2:0][GYRO_W-1:0] g;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [DATA_W-1:0] fifo_data;
   assign g = {gyro_z, gyro_y, gyro_x};

   function automatic logic [BW-1:0] avg_step(input logic [BW-1:0] b, input logic [GYRO_W-1:0] s);
      logic signed [BW:0] d;
      d = $signed({s[GYRO_W-1], s, {BIAS_FRAC{1'b0}}}) - $signed({b[BW-1], b});
      avg_step = BW'($signed({b[BW-1], b}) + (d >>> AVG_SHIFT));
   endfunction : avg_step

   function automatic logic [GYRO_W:0] abs_dev(input logic [BW-1:0] b, input logic [GYRO_W-1:0] s);
      logic signed [GYRO_W:0] d;
      d = $signed({s[GYRO_W-1], s}) - $signed({b[BW-1], b[BW-1:BIAS_FRAC]});
      abs_dev = d[GYRO_W] ? (GYRO_W+1)'(-d) : d;
   endfunction : abs_dev

   function automatic logic [16:0] coef_of(input lp_sel_type sel);
      case (sel)
         LP_A100: coef_of = COEF_A100;
         LP_A050: coef_of = COEF_A050;
         LP_A010: coef_of = COEF_A010;
         LP_A005: coef_of = COEF_A005;
         LP_A001: coef_of = COEF_A001;
         default: coef_of = 17'h00000;
      endcase
   endfunction : coef_of

   sample_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(r.st_valid),
      .in_ready(fifo_in_ready),
      .in_data(r.st_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   always_comb begin
      logic mov;
      logic [GYRO_W:0] dev;
      logic signed [AW:0] diff;
      logic signed [AW+18:0] prod;
      logic [AW-1:0] acc_new;
      logic [DATA_W-1:0] y;
      lp_sel_type lp_new;
      n = r;
      mov = 1'b0;
      dev = '0;
      diff = '0;
      prod = '0;
      acc_new = r.acc;
      y = r.last;
      lp_new = LP_OFF;
      fifo_pop = 1'b0;
      // gyro motion check against the current bias
      for (int i = 0; i < 3; i++) begin
         if (abs_dev(r.bias[i], g[i]) > r.thr) begin
            mov = 1'b1;
         end
      end
      if (gyro_valid) begin
         n.moving = mov;
      end
      // acquisition rate watchdog
      if (reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_CLR_BIT]) begin
         n.slow = 1'b0;
      end
      if (gyro_valid) begin
         n.acq_cnt = '0;
      end else if (r.acq_cnt != ACQ_GAP) begin
         n.acq_cnt = r.acq_cnt + 32'h1;
      end
      if (!gyro_valid && r.acq_cnt == ACQ_GAP - 1) begin
         n.slow = 1'b1;
      end
      // calibration sequencing
      case (r.st)
         ST_IDLE: begin
            if (gyro_valid && mov) begin
               n.still_cnt = '0;
            end else if (r.still_cnt != STILL_CYC) begin
               n.still_cnt = r.still_cnt + 32'h1;
            end
            if (r.auto_en && gyro_valid && !mov && r.still_cnt == STILL_CYC) begin
               for (int i = 0; i < 3; i++) begin
                  n.bias[i] = avg_step(r.bias[i], g[i]);
               end
            end
            if (reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_BASIC_BIT]) begin
               n.st = ST_BASIC;
               n.cal_cnt = '0;
               n.thr = '0;
            end else if (reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_ADV_BIT]) begin
               n.st = ST_ADV;
               n.cal_cnt = '0;
               n.axis = 2'h0;
            end
         end
         ST_BASIC: begin
            n.cal_cnt = r.cal_cnt + 32'h1;
            if (gyro_valid) begin
               for (int i = 0; i < 3; i++) begin
                  n.bias[i] = avg_step(r.bias[i], g[i]);
                  dev = abs_dev(r.bias[i], g[i]);
                  if (r.cal_cnt >= CAL_CYC / 2 && dev > n.thr) begin
                     n.thr = dev;
                  end
               end
            end
            if (r.cal_cnt == CAL_CYC - 1) begin
               n.st = ST_IDLE;
               n.still_cnt = '0;
            end
         end
         ST_ADV: begin
            n.cal_cnt = r.cal_cnt + 32'h1;
            if (gyro_valid) begin
               for (int j = 0; j < 3; j++) begin
                  n.mat[3*r.axis+j] = avg_step(r.mat[3*r.axis+j], g[j]);
               end
            end
            if (r.cal_cnt == AXIS_CYC - 1) begin
               n.st = (r.axis == 2'h2) ? ST_IDLE : ST_WAIT;
               n.axis = (r.axis == 2'h2) ? 2'h0 : r.axis + 2'h1;
               n.still_cnt = '0;
            end
         end
         ST_WAIT: begin
            if (reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_NEXT_BIT]) begin
               n.st = ST_ADV;
               n.cal_cnt = '0;
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase
      // control register
      if (reg_wr && reg_addr == REG_CTRL) begin
         lp_new = lp_sel_type'(reg_wdata[CTRL_LP_LSB +: 3]);
         if (lp_new > LP_A001) begin
            lp_new = LP_OFF;
         end
         n.lp = lp_new;
         if (lp_new != r.lp) begin
            n.prime = 1'b1;
         end
         n.thr_en = reg_wdata[CTRL_THR_BIT];
         n.auto_en = reg_wdata[CTRL_AUTO_BIT];
         n.rot_en = reg_wdata[CTRL_ROT_BIT];
         n.lin = (reg_wdata[CTRL_LIN_LSB +: 2] == 2'h3) ? LIN_STRONG
                 : lin_mode_type'(reg_wdata[CTRL_LIN_LSB +: 2]);
      end
      // smoothing stage
      if (r.st_valid && fifo_in_ready) begin
         n.st_valid = 1'b0;
      end
      if (fused_valid && r.fused_ready) begin
         if (r.thr_en && !r.moving) begin
            y = r.last;
         end else if (r.lp == LP_OFF) begin
            y = fused_data;
         end else if (r.prime) begin
            acc_new = {fused_data, {COEF_FRAC{1'b0}}};
            y = fused_data;
            n.prime = 1'b0;
         end else begin
            diff = $signed({fused_data[DATA_W-1], fused_data, {COEF_FRAC{1'b0}}})
                   - $signed({r.acc[AW-1], r.acc});
            prod = diff * $signed({1'b0, coef_of(r.lp)});
            acc_new = AW'($signed(r.acc) + (prod >>> COEF_FRAC));
            y = acc_new[AW-1:COEF_FRAC];
         end
         n.acc = acc_new;
         n.last = y;
         n.st_valid = 1'b1;
         n.st_data = y;
      end
      n.fused_ready = !n.st_valid;
      // output pacing
      if (r.gap_cnt != OUT_GAP) begin
         n.gap_cnt = r.gap_cnt + 32'h1;
      end
      if (r.out_valid && out_ready) begin
         n.out_valid = 1'b0;
      end
      if (fifo_out_valid && (!r.out_valid || out_ready) && r.gap_cnt >= OUT_GAP - 1) begin
         fifo_pop = 1'b1;
         n.out_valid = 1'b1;
         n.out_data = fifo_data;
         n.gap_cnt = '0;
      end
      // register reads
      n.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            REG_CTRL: begin
               n.rdata[CTRL_LP_LSB +: 3] = r.lp;
               n.rdata[CTRL_THR_BIT] = r.thr_en;
               n.rdata[CTRL_AUTO_BIT] = r.auto_en;
               n.rdata[CTRL_ROT_BIT] = r.rot_en;
               n.rdata[CTRL_LIN_LSB +: 2] = r.lin;
            end
            REG_STATUS: begin
               n.rdata[STAT_BASIC_BIT] = (r.st == ST_BASIC);
               n.rdata[STAT_ADV_BIT] = (r.st == ST_ADV);
               n.rdata[STAT_WAIT_BIT] = (r.st == ST_WAIT);
               n.rdata[STAT_SLOW_BIT] = r.slow;
               n.rdata[STAT_MOVE_BIT] = r.moving;
               n.rdata[STAT_AXIS_LSB +: 2] = r.axis;
            end
            REG_THRESH: begin
               n.rdata = 32'(r.thr);
            end
            default: begin
               for (int i = 0; i < 3; i++) begin
                  if (reg_addr == 8'(REG_BIAS + 4 * i)) begin
                     n.rdata = 32'($signed(r.bias[i][BW-1:BIAS_FRAC]));
                  end
               end
               for (int k = 0; k < 9; k++) begin
                  if (reg_addr == 8'(REG_MATRIX + 4 * k)) begin
                     n.rdata = 32'($signed(r.mat[k][BW-1:BIAS_FRAC]));
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.lp <= LP_RESET;
         r.thr_en <= THR_EN_RESET;
         r.auto_en <= AUTO_EN_RESET;
         r.rot_en <= ROT_EN_RESET;
         r.lin <= LIN_RESET;
         r.prime <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign reg_rdata = r.rdata;
   assign fused_ready = r.fused_ready;
   assign out_valid = r.out_valid;
   assign out_data = r.out_data;
   assign lin_acc_mode = r.lin;
   assign rot_acc_en = r.rot_en;
endmodule : orient_filter

// *** verif/orient_filter_props.sv ***
`timescale 1ns/1ps
module orient_filter_props
   import orient_filter_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter int unsigned OUT_GAP = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // stream
   input wire logic fused_valid,
   input wire logic fused_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [DATA_W-1:0] out_data,
   // fusion settings
   input wire logic [1:0] lin_acc_mode,
   input wire logic rot_acc_en
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic valid_q;
   int unsigned gap;
   // cycles since out_valid last rose, saturating
   always_ff @(posedge ref_clk) begin
      valid_q <= out_valid;
      if (!rst_n) begin
         gap <= OUT_GAP;
      end else if (out_valid && !valid_q) begin
         gap <= 1;
      end else if (gap < OUT_GAP) begin
         gap <= gap + 1;
      end
   end
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   cmd_rd_a: assert property (reg_rd && reg_addr == REG_CMD |=> reg_rdata == 32'h0)
      else $error("command register read not zero");
   set_reset_a: assert property (!$past(rst_n) |-> lin_acc_mode == 2'h2 && !rot_acc_en)
      else $error("fusion settings wrong after reset");
   lin_wr_a: assert property (reg_wr && reg_addr == REG_CTRL |=>
      lin_acc_mode == ($past(reg_wdata[7:6]) == 2'h3 ? 2'h2 : $past(reg_wdata[7:6])))
      else $error("linear mode not taken from write");
   rot_wr_a: assert property (reg_wr && reg_addr == REG_CTRL |=> rot_acc_en == $past(reg_wdata[5]))
      else $error("rotation switch not taken from write");
   lin_legal_a: assert property (lin_acc_mode != 2'h3)
      else $error("linear mode illegal");
   out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("output dropped or changed while stalled");
   out_gap_a: assert property ($rose(out_valid) |-> gap >= OUT_GAP)
      else $error("output samples too close");
   take_gap_a: assert property (fused_valid && fused_ready |=> !fused_ready)
      else $error("input taken on two cycles in a row");
   ready_reset_a: assert property (!$past(rst_n) |-> !fused_ready && !out_valid)
      else $error("stream active at reset release");
endmodule : orient_filter_props

bind orient_filter orient_filter_props #(.DATA_W(DATA_W), .OUT_GAP(OUT_GAP)) props (
   .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fused_valid(fused_valid),
   .fused_ready(fused_ready), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
   .lin_acc_mode(lin_acc_mode), .rot_acc_en(rot_acc_en));

// *** verif/orient_sink.sv ***
`timescale 1ns/1ps
module orient_sink (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // stall request
   input wire logic stall,
   // stream
   input wire logic out_valid,
   output logic out_ready,
   input wire logic [15:0] out_data,
   // capture
   output int got_count,
   output logic [15:0] got_data
);
   // host reads one sample per handshake, may stall
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         out_ready <= 1'b0;
         got_count <= 0;
         got_data <= 16'h0;
      end else begin
         out_ready <= !stall;
         if (out_valid && out_ready) begin
            got_data <= out_data;
            got_count <= got_count + 1;
         end
      end
   end
endmodule : orient_sink

// *** verif/orient_filter_bench.sv ***
`timescale 1ns/1ps
module orient_filter_bench;
   import orient_filter_pkg::*;
   logic ref_clk = '0, rst_n = '0, reg_wr = '0, reg_rd = '0, gyro_valid = '0;
   logic fused_valid = '0, stall = '0, gyro_run = '0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata;
   logic [15:0] gval = '0, fused_data = '0, out_data, got_data, last;
   logic fused_ready, out_valid, out_ready, rot_acc_en;
   logic [1:0] lin_acc_mode, gdiv = '0;
   int errors, checks, cycles, seen, got_count;
   orient_filter #(.CAL_CYC(32'hC8), .AXIS_CYC(32'h64), .STILL_CYC(32'h14), .OUT_GAP(32'h4),
      .ACQ_GAP(32'h32)) DUT (
      .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gyro_valid(gyro_valid),
      .gyro_x(gval), .gyro_y(gval), .gyro_z(gval), .fused_valid(fused_valid),
      .fused_ready(fused_ready), .fused_data(fused_data), .out_valid(out_valid),
      .out_ready(out_ready), .out_data(out_data), .lin_acc_mode(lin_acc_mode),
      .rot_acc_en(rot_acc_en));
   orient_sink sink (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall), .out_valid(out_valid),
      .out_ready(out_ready), .out_data(out_data), .got_count(got_count), .got_data(got_data));
   always #25 ref_clk = ~ref_clk;
   // gyro sample every fourth cycle, watchdog
   always @(posedge ref_clk) begin
      gdiv <= gdiv + 2'h1;
      gyro_valid <= gyro_run && gdiv == 2'h0;
      cycles++;
      if (cycles == 30000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic send(input logic [15:0] d, output bit ok);
      int n;
      n = 0;
      @(posedge ref_clk);
      fused_data <= d;
      fused_valid <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (fused_ready !== 1'b1 && n < 40);
      ok = fused_ready === 1'b1;
      fused_valid <= 1'b0;
   endtask : send
   task automatic recv(input logic [15:0] e);
      int n;
      n = 0;
      while (got_count == seen && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      chk(32'(got_count != seen), 32'h1);
      seen++;
      last = e;
      chk({16'h0, got_data}, {16'h0, e});
   endtask : recv
   task automatic xfer(input logic [15:0] d, input logic [15:0] e);
      bit ok;
      send(d, ok);
      recv(e);
   endtask : xfer
   task automatic t_regs;
      logic [31:0] d;
      rd(REG_CTRL, d);
      chk(d, 32'h90);
      chk({29'h0, lin_acc_mode, rot_acc_en}, 32'h4);
      for (int m = 0; m < 4; m++) begin
         wr(REG_CTRL, 32'h20 | 32'(m << 6));
         chk({29'h0, lin_acc_mode, rot_acc_en}, 32'((m == 3 ? 2 : m) * 2 + 1));
      end
      wr(REG_CTRL, 32'h96);
      rd(REG_CTRL, d);
      chk(d, 32'h90);
      chk({31'h0, rot_acc_en}, 32'h0);
      wr(REG_THRESH, 32'h55);
      rd(REG_THRESH, d);
      chk(d, 32'h0);
      rd(8'h80, d);
      chk(d, 32'h0);
   endtask : t_regs
   task automatic t_fifo;
      logic [15:0] q[$];
      bit ok;
      ok = 1;
      stall <= 1'b1;
      while (ok && q.size() < 40) begin
         send(16'h1000 + 16'(q.size()), ok);
         if (ok) q.push_back(16'h1000 + 16'(q.size()));
      end
      chk(32'(q.size() >= 32 && q.size() < 40), 32'h1);
      stall <= 1'b0;
      foreach (q[i]) recv(q[i]);
   endtask : t_fifo
   task automatic t_lp;
      logic [16:0] c [5] = '{COEF_A100, COEF_A050, COEF_A010, COEF_A005, COEF_A001};
      longint acc;
      for (int s = 1; s <= 5; s++) begin
         wr(REG_CTRL, 32'h90 | 32'(s));
         xfer(16'h0064, 16'h0064);
         acc = longint'(100) <<< 16;
         for (int k = 0; k < 2; k++) begin
            acc = acc + ((((longint'(16384) <<< 16) - acc) * longint'(c[s - 1])) >>> 16);
            xfer(16'h4000, 16'(acc >>> 16));
         end
      end
      wr(REG_CTRL, 32'h90);
   endtask : t_lp
   task automatic t_cal;
      logic [31:0] d, b;
      rd(REG_STATUS, d);
      chk({31'h0, d[3]}, 32'h1);
      gval <= 16'h8;
      gyro_run <= 1'b1;
      wr(REG_CMD, 32'h8);
      rd(REG_STATUS, d);
      chk({31'h0, d[3]}, 32'h0);
      wr(REG_CMD, 32'h1);
      wr(REG_CMD, 32'h2);
      rd(REG_STATUS, d);
      chk({29'h0, d[2:0]}, 32'h1);
      repeat (180) @(posedge ref_clk);
      rd(REG_STATUS, d);
      chk({29'h0, d[2:0]}, 32'h1);
      repeat (15) @(posedge ref_clk);
      rd(REG_STATUS, d);
      chk({29'h0, d[2:0]}, 32'h0);
      rd(REG_BIAS, b);
      chk(32'(b > 0 && b <= 8), 32'h1);
      rd(REG_THRESH, d);
      chk(32'(d > 0 && d <= 8), 32'h1);
      repeat (300) @(posedge ref_clk);
      rd(REG_BIAS, d);
      chk(32'(d > b), 32'h1);
      wr(REG_CTRL, 32'h98);
      xfer(16'h0AAA, last);
      gval <= 16'h0800;
      repeat (8) @(posedge ref_clk);
      rd(REG_STATUS, d);
      chk({31'h0, d[4]}, 32'h1);
      xfer(16'h0BBB, 16'h0BBB);
      wr(REG_CTRL, 32'h90);
   endtask : t_cal
   task automatic t_adv;
      logic [31:0] d;
      for (int a = 0; a < 3; a++) begin
         wr(REG_CMD, a == 0 ? 32'h2 : 32'h4);
         rd(REG_STATUS, d);
         chk(32'({d[6:5], d[2:0]}), 32'({2'(a), 3'h2}));
         repeat (108) @(posedge ref_clk);
         rd(REG_STATUS, d);
         if (a < 2) chk(32'({d[6:5], d[2:0]}), 32'({2'(a + 1), 3'h4}));
         else chk({29'h0, d[2:0]}, 32'h0);
      end
      rd(REG_MATRIX, d);
      chk(32'(d > 0 && d <= 32'h800), 32'h1);
   endtask : t_adv
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs();
      t_fifo();
      t_lp();
      t_cal();
      t_adv();
      tally_and_finish();
   end
endmodule : orient_filter_bench
